// *** core/dcc_core.sv ***
// Purpose: Core control and RAM configuration registers with modulo addressing
// Assumes: Register access by index with one-cycle write and read strobes
// Notes: LRCLK inputs are synchronised with three flip-flops
// Summary of operation
// - Slew-muted status bit 13 sets after mute completes, clears on read.
// - Bit 12 mutes all 64 slew locations; clearing restores prior values.
// - Mute acts as zero data; time constant and curve bits kept.
// - Output latch on end of program, or output LRCLK when bit 10 set.
// - Bit 9 low holds accumulators and outputs at zero; resets low.
// - Bit 8 forces multiplier input to zero.
// - Bit 7 zeros whole data memory, then self-clears.
// - Bit 6 forces all 16 serial input channels to zero.
// - Bit 5 starts safeload to target RAM; clears when done.
// - Bit 4 starts safeload to parameter RAM; clears when done.
// - Only safeload pairs written since the previous safeload are copied.
// - Bits 3:2 divide input LRCLK by 1, 2, 4 or 8 for sync.
// - Sequencer aligns its program counter to selected input LRCLK edge.
// - Bits 1:0 set program length 1536, 768, 384 or 192.
// - Modulo field bits 3:0 in units of 512 words, max 0b1100; values above it are stored unchanged.
// - Offset counter added to base address, advanced once per frame.
// - Addresses below modulo boundary wrap with offset; above accessed directly.
// - Default configuration makes all 6144 words modulo memory.
// - Safeload completes within one LRCLK frame of trigger.
module dcc_core
    import dcc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [10:0] REG_IDX,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    input wire logic LRCLK_IN,
    input wire logic LRCLK_OUT,
    input wire logic SLEW_MUTE_DONE,
    input wire logic SL_PAIR_WR,
    input wire logic [2:0] SL_PAIR_IDX,
    input wire logic [12:0] DM_BASE_ADDR,
    output logic [12:0] DM_ADDR,
    output logic DM_WE,
    output logic SLEW_MUTE,
    output logic OUT_LATCH,
    output logic CLEAR_ACC,
    output logic MULT_ZERO,
    output logic IN_MUTE,
    output logic SL_WE,
    output logic SL_TARGET,
    output logic [2:0] SL_IDX,
    output logic SEQ_SYNC,
    output logic [10:0] PROG_LAST
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] lri_s_r;
    logic [2:0] lro_s_r;
    logic lri_st_r;
    logic lro_st_r;
    always_ff @(posedge CLK) begin
        lri_s_r <= {lri_s_r[1:0], LRCLK_IN};
        lro_s_r <= {lro_s_r[1:0], LRCLK_OUT};
    end
    wire lri_agree = lri_s_r[1] == lri_s_r[2];
    wire lro_agree = lro_s_r[1] == lro_s_r[2];
    always_ff @(posedge CLK) begin
        if (RST) begin
            lri_st_r <= 1'b0;
            lro_st_r <= 1'b0;
        end else begin
            if (lri_agree) lri_st_r <= lri_s_r[2];
            if (lro_agree) lro_st_r <= lro_s_r[2];
        end
    end
    wire lri_rise = lri_agree && lri_s_r[2] && !lri_st_r;
    wire lro_rise = lro_agree && lro_s_r[2] && !lro_st_r;

    ////////////////////////////////////////////////////////////////////////
    // Registers and decode
    logic [15:0] ctrl_r;
    logic [3:0] mod_r;
    logic muted_r;
    wire ctrl_hit = REG_IDX == DCC_CORE_CTRL_IDX;
    wire cfg_hit = REG_IDX == DCC_RAM_CFG_IDX;
    wire ctrl_wr = REG_WR && ctrl_hit;
    wire cfg_wr = REG_WR && cfg_hit;
    wire ctrl_rd = REG_RD && ctrl_hit;
    logic dm_done;
    logic sl_done;
    logic [15:0] ctrl_nxt;
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_wr) ctrl_nxt = REG_WDATA & DCC_CORE_WMASK;
        if (dm_done) ctrl_nxt[DCC_B_DM_INIT] = 1'b0;
        if (sl_done) begin
            ctrl_nxt[DCC_B_SL_TARGET] = 1'b0;
            ctrl_nxt[DCC_B_SL_PARAM] = 1'b0;
        end
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_r <= DCC_CORE_CTRL_RST;
            mod_r <= DCC_RAM_CFG_RST;
            muted_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (cfg_wr) mod_r <= REG_WDATA[3:0];
            if (SLEW_MUTE_DONE && ctrl_r[DCC_B_SLEW_MUTE]) muted_r <= 1'b1;
            else if (ctrl_rd || !ctrl_r[DCC_B_SLEW_MUTE]) muted_r <= 1'b0;
        end
    end
    wire [15:0] ctrl_view = {2'b00, muted_r, ctrl_r[12:0]};
    wire [15:0] rd_mux = ctrl_hit ? ctrl_view : cfg_hit ? {12'h000, mod_r} : 16'h0000;
    always_ff @(posedge CLK) begin
        if (RST) REG_RDATA <= 16'h0000;
        else if (REG_RD) REG_RDATA <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame divider and sequencer
    logic [2:0] div_r;
    logic [10:0] pc_r;
    wire [1:0] sync_sel = ctrl_r[3:2];
    wire div_hit = (sync_sel == 2'b00) || ((div_r & ((3'h1 << sync_sel) - 3'h1)) == 3'h0);
    wire frame = lri_rise && div_hit;
    wire [10:0] plast = ctrl_r[1:0] == 2'b00 ? DCC_PLEN_1536 :
                        ctrl_r[1:0] == 2'b01 ? DCC_PLEN_768 :
                        ctrl_r[1:0] == 2'b10 ? DCC_PLEN_384 : DCC_PLEN_192;
    wire pc_end = pc_r == plast;
    always_ff @(posedge CLK) begin
        if (RST) begin
            div_r <= 3'h0;
            pc_r <= 11'h000;
        end else begin
            if (lri_rise) div_r <= div_r + 3'h1;
            if (frame) pc_r <= 11'h000;
            else if (!pc_end) pc_r <= pc_r + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Modulo addressing
    logic [12:0] ofs_r;
    wire [12:0] mod_size = 13'(mod_r * DCC_MOD_UNIT);
    wire [13:0] mod_sum = {1'b0, DM_BASE_ADDR} + {1'b0, ofs_r};
    wire [12:0] mod_addr = mod_sum >= {1'b0, mod_size} ? 13'(mod_sum - {1'b0, mod_size}) :
                           mod_sum[12:0];
    wire in_mod = DM_BASE_ADDR < mod_size;
    wire [12:0] ofs_inc = ofs_r + 13'h0001;
    always_ff @(posedge CLK) begin
        if (RST) ofs_r <= 13'h0000;
        else if (cfg_wr) ofs_r <= 13'h0000;
        else if (frame) ofs_r <= (ofs_inc >= mod_size) ? 13'h0000 : ofs_inc;
    end

    ////////////////////////////////////////////////////////////////////////
    // Data memory zeroing
    logic [12:0] init_r;
    logic init_busy_r;
    assign dm_done = init_busy_r && init_r == DCC_DM_LAST;
    always_ff @(posedge CLK) begin
        if (RST) begin
            init_r <= 13'h0000;
            init_busy_r <= 1'b0;
        end else if (init_busy_r) begin
            init_r <= init_r + 13'h0001;
            if (dm_done) init_busy_r <= 1'b0;
        end else if (ctrl_r[DCC_B_DM_INIT]) begin
            init_r <= 13'h0000;
            init_busy_r <= 1'b1;
        end
    end
    wire [12:0] addr_nxt = init_busy_r ? init_r : in_mod ? mod_addr : DM_BASE_ADDR;

    ////////////////////////////////////////////////////////////////////////
    // Safeload pair tracking and transfer
    logic [DCC_SL_PAIRS-1:0] dirty_r;
    logic [2:0] sl_cnt_r;
    logic sl_busy_r;
    logic sl_tgt_r;
    wire sl_req = ctrl_r[DCC_B_SL_TARGET] || ctrl_r[DCC_B_SL_PARAM];
    wire sl_last = sl_cnt_r == DCC_SL_LAST;
    assign sl_done = sl_busy_r && sl_last;
    genvar gi;
    generate
        for (gi = 0; gi < DCC_SL_PAIRS; gi++) begin : g_dirty
            always_ff @(posedge CLK) begin
                if (RST) dirty_r[gi] <= 1'b0;
                else if (SL_PAIR_WR && SL_PAIR_IDX == 3'(gi)) dirty_r[gi] <= 1'b1;
                else if (sl_busy_r && sl_cnt_r == 3'(gi)) dirty_r[gi] <= 1'b0;
            end
        end
    endgenerate
    always_ff @(posedge CLK) begin
        if (RST) begin
            sl_cnt_r <= 3'h0;
            sl_busy_r <= 1'b0;
            sl_tgt_r <= 1'b0;
        end else if (sl_busy_r) begin
            sl_cnt_r <= sl_cnt_r + 3'h1;
            if (sl_last) sl_busy_r <= 1'b0;
        end else if (sl_req && pc_end) begin
            sl_cnt_r <= 3'h0;
            sl_busy_r <= 1'b1;
            sl_tgt_r <= ctrl_r[DCC_B_SL_TARGET];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    // End-of-program edge, so the latch is one pulse while the counter stalls
    logic pend_r;
    always_ff @(posedge CLK) begin
        if (RST) pend_r <= 1'b0;
        else pend_r <= pc_end;
    end
    wire latch_nxt = ctrl_r[DCC_B_OUT_LRCLK] ? lro_rise : pc_end && !pend_r && !frame;

    always_ff @(posedge CLK) begin
        if (RST) begin
            DM_ADDR <= 13'h0000;
        end else begin
            DM_ADDR <= addr_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            DM_WE <= 1'b0;
        end else begin
            DM_WE <= init_busy_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            SLEW_MUTE <= 1'b0;
        end else begin
            SLEW_MUTE <= ctrl_r[DCC_B_SLEW_MUTE];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            OUT_LATCH <= 1'b0;
        end else begin
            OUT_LATCH <= latch_nxt && ctrl_r[DCC_B_CLEAR_N];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            CLEAR_ACC <= 1'b1;
        end else begin
            CLEAR_ACC <= !ctrl_r[DCC_B_CLEAR_N];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            MULT_ZERO <= 1'b0;
        end else begin
            MULT_ZERO <= ctrl_r[DCC_B_MULT_ZERO];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            IN_MUTE <= 1'b0;
        end else begin
            IN_MUTE <= ctrl_r[DCC_B_IN_MUTE];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            SL_WE <= 1'b0;
        end else begin
            SL_WE <= sl_busy_r && dirty_r[sl_cnt_r];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            SL_TARGET <= 1'b0;
        end else begin
            SL_TARGET <= sl_tgt_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            SL_IDX <= 3'h0;
        end else begin
            SL_IDX <= sl_cnt_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            SEQ_SYNC <= 1'b0;
        end else begin
            SEQ_SYNC <= frame;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            PROG_LAST <= DCC_PLEN_1536;
        end else begin
            PROG_LAST <= plast;
        end
    end
endmodule // dcc_core

// *** core/dcc_pkg.sv ***
// Purpose: Shared constants for the core control and modulo RAM block
// Assumes: 16-bit control register, 4-bit RAM configuration register
// Notes: Offsets are register indices on the control port
package dcc_pkg;
    localparam logic [10:0] DCC_CORE_CTRL_IDX = 11'ha52;
    localparam logic [10:0] DCC_RAM_CFG_IDX = 11'ha53;
    localparam logic [15:0] DCC_CORE_CTRL_RST = 16'h0000;
    localparam logic [3:0] DCC_RAM_CFG_RST = 4'hc;
    localparam logic [15:0] DCC_CORE_WMASK = 16'h17ff;
    localparam int DCC_B_MUTED = 13;
    localparam int DCC_B_SLEW_MUTE = 12;
    localparam int DCC_B_OUT_LRCLK = 10;
    localparam int DCC_B_CLEAR_N = 9;
    localparam int DCC_B_MULT_ZERO = 8;
    localparam int DCC_B_DM_INIT = 7;
    localparam int DCC_B_IN_MUTE = 6;
    localparam int DCC_B_SL_TARGET = 5;
    localparam int DCC_B_SL_PARAM = 4;
    localparam int DCC_SLEW_LOCS = 64;
    localparam int DCC_SL_PAIRS = 5;
    localparam int DCC_IN_CHANS = 16;
    localparam int DCC_DM_WORDS = 6144;
    localparam logic [12:0] DCC_DM_LAST = 13'h17ff;
    localparam logic [12:0] DCC_MOD_UNIT = 13'h0200;
    localparam logic [10:0] DCC_PLEN_1536 = 11'h5ff;
    localparam logic [10:0] DCC_PLEN_768 = 11'h2ff;
    localparam logic [10:0] DCC_PLEN_384 = 11'h17f;
    localparam logic [10:0] DCC_PLEN_192 = 11'h0bf;
    localparam logic [5:0] DCC_SLEW_LAST = 6'h3f;
    localparam logic [2:0] DCC_SL_LAST = 3'h4;
endpackage : dcc_pkg

// *** testbench/dcc_core_props.sv ***
// Purpose: Port checker for dcc_core
// Assumes: Sync active-high reset
// Notes: Bound from the bench top file
module dcc_core_props
    import dcc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [10:0] REG_IDX,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic [12:0] DM_ADDR,
    input wire logic DM_WE,
    input wire logic SLEW_MUTE,
    input wire logic OUT_LATCH,
    input wire logic CLEAR_ACC,
    input wire logic MULT_ZERO,
    input wire logic IN_MUTE,
    input wire logic SL_WE,
    input wire logic [2:0] SL_IDX,
    input wire logic SEQ_SYNC,
    input wire logic [10:0] PROG_LAST
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [10:0] PL [4] = '{DCC_PLEN_1536, DCC_PLEN_768, DCC_PLEN_384, DCC_PLEN_192};
    wire logic cw = REG_WR && (REG_IDX == DCC_CORE_CTRL_IDX);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_cw;
        cw ##1 !cw;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_SLEW: assert property (s_cw |-> ##1 SLEW_MUTE == $past(REG_WDATA[12], 2))
        else $error("slew mute wrong");
    AST_CLEAR: assert property (s_cw |-> ##1 CLEAR_ACC == !$past(REG_WDATA[9], 2))
        else $error("clear level wrong");
    AST_ZERO: assert property (s_cw |-> ##1 MULT_ZERO == $past(REG_WDATA[8], 2))
        else $error("mult zero wrong");
    AST_IN_MUTE: assert property (s_cw |-> ##1 IN_MUTE == $past(REG_WDATA[6], 2))
        else $error("input mute wrong");
    AST_PLEN: assert property (s_cw |-> ##1 PROG_LAST == PL[$past(REG_WDATA[1:0], 2)])
        else $error("program length wrong");
    AST_RSV_CORE: assert property (REG_RD && REG_IDX == DCC_CORE_CTRL_IDX |=>
        REG_RDATA[15:14] == 2'h0 && !REG_RDATA[11])
        else $error("core reserved bits set");
    AST_RSV_CFG: assert property (REG_RD && REG_IDX == DCC_RAM_CFG_IDX |=> REG_RDATA[15:4] == 12'h000)
        else $error("cfg reserved bits set");
    AST_GATE: assert property (CLEAR_ACC && $past(CLEAR_ACC) |-> !OUT_LATCH)
        else $error("latch while cleared");
    AST_WALK: assert property (DM_WE && $past(DM_WE) |-> DM_ADDR == $past(DM_ADDR) + 13'h1)
        else $error("zeroing walk broken");
    AST_SL_IDX: assert property (SL_WE |-> SL_IDX <= DCC_SL_LAST)
        else $error("pair index out of range");
    AST_SYNC: assert property (SEQ_SYNC |=> !SEQ_SYNC)
        else $error("sync not a pulse");
    C_INIT: cover property (DM_WE);
    C_SL: cover property (SL_WE);
    C_SYNC: cover property (SEQ_SYNC);
endmodule // dcc_core_props

// *** testbench/test_dsp_core_control_modulo_ram.sv ***
// Purpose: Self-checking bench for core control and modulo RAM
// Assumes: Input frame clock free-running, 2048 cycles a frame
// Notes: Reset held 20 cycles
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module test_dsp_core_control_modulo_ram
    import dcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic lro = 1'b0;
    logic mdone = 1'b0;
    logic pwr = 1'b0;
    logic [10:0] idx = '0;
    logic [15:0] wd = '0;
    logic [2:0] pidx = '0;
    logic [12:0] base = '0;
    logic [10:0] fcnt = '0;
    int mismatches = 0;
    int tests_run = 0;
    logic [15:0] rdata;
    logic [12:0] dm_addr;
    logic [10:0] plast;
    logic [2:0] sl_idx;
    logic dm_we, smute, olatch, clr, mz, imute, sl_we, sl_tgt, ssync;
    dcc_core uut (.CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_IDX(idx),
        .REG_WDATA(wd), .REG_RDATA(rdata), .LRCLK_IN(fcnt[10]), .LRCLK_OUT(lro),
        .SLEW_MUTE_DONE(mdone), .SL_PAIR_WR(pwr), .SL_PAIR_IDX(pidx), .DM_BASE_ADDR(base),
        .DM_ADDR(dm_addr), .DM_WE(dm_we), .SLEW_MUTE(smute), .OUT_LATCH(olatch),
        .CLEAR_ACC(clr), .MULT_ZERO(mz), .IN_MUTE(imute), .SL_WE(sl_we), .SL_TARGET(sl_tgt),
        .SL_IDX(sl_idx), .SEQ_SYNC(ssync), .PROG_LAST(plast));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) fcnt <= fcnt + 11'h1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [10:0] i, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        idx <= i;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [10:0] i, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        idx <= i;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task automatic wait_sync();
        for (int n = 0; n < 20000 && ssync !== 1'b1; n++) @(negedge clk);
    endtask
    task automatic addr_chk(input logic [12:0] b, input logic [12:0] e);
        @(posedge clk);
        base <= b;
        @(posedge clk);
        #1 `CHK(dm_addr, e)
    endtask
    task automatic lat_cnt(input int cyc, input int e);
        int n = 0;
        repeat (2) @(posedge clk);
        repeat (cyc) begin
            @(negedge clk);
            n += int'(olatch === 1'b1);
        end
        `CHK(n, e)
    endtask
    task automatic t_bits();
        logic [10:0] pl [4] = '{DCC_PLEN_1536, DCC_PLEN_768, DCC_PLEN_384, DCC_PLEN_192};
        int n = 0;
        for (int k = 0; k < 4; k++) begin
            wr_reg(DCC_CORE_CTRL_IDX, 16'hef40 | 16'(k * 5));
            rd_chk(DCC_CORE_CTRL_IDX, 16'h0740 | 16'(k * 5));
            `CHK(plast, pl[k])
        end
        `CHK({mz, imute, clr}, 3'b110)
        wait_sync();
        do begin
            @(negedge clk);
            n++;
        end while (ssync !== 1'b1 && n < 20000);
        `CHK(n, 16384)
    endtask
    task automatic t_safe(input logic [15:0] trig, input logic [4:0] dirty);
        logic [4:0] seen = '0;
        for (int p = 0; p < 5; p++) begin
            if (dirty[p]) begin
                @(posedge clk);
                pwr <= 1'b1;
                pidx <= 3'(p);
                @(posedge clk);
                pwr <= 1'b0;
            end
        end
        wr_reg(DCC_CORE_CTRL_IDX, 16'h0200 | trig);
        repeat (2100) begin
            @(negedge clk);
            if (sl_we === 1'b1) begin
                seen[sl_idx] = 1'b1;
                `CHK(sl_tgt, trig[5])
            end
        end
        `CHK(seen, dirty)
        rd_chk(DCC_CORE_CTRL_IDX, 16'h0200);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        int n;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk(DCC_CORE_CTRL_IDX, 16'h0000);
        rd_chk(DCC_RAM_CFG_IDX, 16'h000c);
        rd_chk(11'h654, 16'h0000);
        `CHK({clr, plast}, {1'b1, DCC_PLEN_1536})
        t_bits();
        wr_reg(DCC_CORE_CTRL_IDX, 16'h0200);
        wait_sync();
        repeat (8) @(posedge clk);
        wr_reg(DCC_RAM_CFG_IDX, 16'hfff5);
        rd_chk(DCC_RAM_CFG_IDX, 16'h0005);
        addr_chk(13'h0100, 13'h0100);
        addr_chk(13'h1000, 13'h1000);
        wait_sync();
        repeat (8) @(posedge clk);
        addr_chk(13'h0100, 13'h0101);
        addr_chk(13'h09ff, 13'h0000);
        wr_reg(DCC_CORE_CTRL_IDX, 16'h1200);
        @(posedge clk);
        mdone <= 1'b1;
        @(posedge clk);
        mdone <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(smute, 1'b1)
        rd_chk(DCC_CORE_CTRL_IDX, 16'h3200);
        rd_chk(DCC_CORE_CTRL_IDX, 16'h1200);
        wr_reg(DCC_CORE_CTRL_IDX, 16'h0280);
        for (n = 0; n < 20 && dm_we !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 7000 && dm_we === 1'b1; n++) @(negedge clk);
        `CHK({smute, 32'(n)}, {1'b0, 32'(DCC_DM_WORDS)})
        rd_chk(DCC_CORE_CTRL_IDX, 16'h0200);
        t_safe(16'h0020, 5'b01010);
        t_safe(16'h0010, 5'b00001);
        lat_cnt(2048, 1);
        wr_reg(DCC_CORE_CTRL_IDX, 16'h0000);
        lat_cnt(2048, 0);
        wr_reg(DCC_CORE_CTRL_IDX, 16'h0600);
        lat_cnt(2048, 0);
        @(posedge clk);
        lro <= 1'b1;
        lat_cnt(16, 1);
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        finish_test();
    end
endmodule // test_dsp_core_control_modulo_ram
bind dcc_core dcc_core_props chk (.CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_IDX(REG_IDX), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .DM_ADDR(DM_ADDR),
    .DM_WE(DM_WE), .SLEW_MUTE(SLEW_MUTE), .OUT_LATCH(OUT_LATCH), .CLEAR_ACC(CLEAR_ACC),
    .MULT_ZERO(MULT_ZERO), .IN_MUTE(IN_MUTE), .SL_WE(SL_WE), .SL_IDX(SL_IDX),
    .SEQ_SYNC(SEQ_SYNC), .PROG_LAST(PROG_LAST));
